//--- cacap_assoc.sv
`timescale 1ns/10ps
module cacap_assoc
   import cacap_pkg::*;
(
   input  wire logic                              sys_clk_i,
   input  wire logic                              reset_n_i,
   input  wire logic                              wr_i,
   input  wire logic [cacap_pkg::CACAP_CPU_W-1:0] wr_cpu_i,
   input  wire logic [63:0]                       wr_data_i,
   output logic      [cacap_pkg::CACAP_NUM_CPU-1:0][cacap_pkg::CACAP_CLS_W-1:0] cls_o
);
   import cacap_pkg::*;

   typedef struct packed {
      logic [CACAP_NUM_CPU-1:0][CACAP_CLS_W-1:0] cls;
   } cacap_assoc_s;

   cacap_assoc_s st_q;
   cacap_assoc_s st_d;

   // Only the class field is kept; upper field bits beyond the class width are dropped
   always_comb begin
      st_d = st_q;
      if (wr_i) begin
         st_d.cls[wr_cpu_i] = wr_data_i[CACAP_ASSOC_LSB +: CACAP_CLS_W];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < CACAP_NUM_CPU; i++) begin
            st_q.cls[i] <= CACAP_CLS_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end

   assign cls_o = st_q.cls;

   AST_ASSOC_FIELD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_i |=> cls_o[$past(wr_cpu_i)] == $past(wr_data_i[35:32]))
      else $error("class field not taken from bits 63:32");
endmodule

//--- cacap_mask_bank.sv
`timescale 1ns/10ps
module cacap_mask_bank
   import cacap_pkg::*;
(
   input  wire logic                           sys_clk_i,
   input  wire logic                           reset_n_i,
   input  wire logic                           wr_i,
   input  wire logic [cacap_pkg::CACAP_CLS_W-1:0] wr_cls_i,
   input  wire logic [15:0]                    wr_data_i,
   input  wire logic [cacap_pkg::CACAP_CLS_W-1:0] rd_cls_a_i,
   input  wire logic [cacap_pkg::CACAP_CLS_W-1:0] rd_cls_b_i,
   output logic      [15:0]                    rd_mask_a_o,
   output logic      [15:0]                    rd_mask_b_o
);
   import cacap_pkg::*;

   typedef struct packed {
      logic [CACAP_NUM_CLASS-1:0][15:0] mask;
   } cacap_bank_s;

   cacap_bank_s st_q;
   cacap_bank_s st_d;

   // One bank per cache, shared by every processor behind that cache
   always_comb begin
      st_d = st_q;
      if (wr_i) begin
         st_d.mask[wr_cls_i] = wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < CACAP_NUM_CLASS; i++) begin
            st_q.mask[i] <= CACAP_MASK_RST;
         end
      end else begin
         st_q <= st_d;
      end
   end

   assign rd_mask_a_o = st_q.mask[rd_cls_a_i];
   assign rd_mask_b_o = st_q.mask[rd_cls_b_i];

   AST_MASK_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      wr_i |=> st_q.mask[$past(wr_cls_i)] == $past(wr_data_i))
      else $error("mask write not stored");
   AST_MASK_RESET: assert property (@(posedge sys_clk_i)
      $rose(reset_n_i) |-> st_q.mask[0] == CACAP_MASK_RST)
      else $error("class 0 mask not all ones after reset");
endmodule

//--- cacap_pkg.sv
// Contract
// - Leaf 07H sub-leaf 0: word B bit 15 flags support
// - Leaf 10H sub-leaf 0: word B resource flags
// - Leaf 10H sub-leaf 0: words A, C, D zero
// - Resource identifier doubles as sub-leaf index
// - Word A bits 4:0 hold mask length minus one
// - Sub-leaf 1 word B: shared last-level units
// - Sub-leaf 2 word B: shared second-level units
// - Sub-leaf 1 word C bit 1: non-processor agents
// - Sub-leaf 1 word C bit 2: last-level code/data split
// - Sub-leaf 2 word C bit 2: second-level code/data split
// - Word C bit 3: non-contiguous masks accepted
// - Word D bits 15:0 hold highest class
// - One writable mask per class per resource
// - Mask banks shared at cache scope
// - Per-processor class field selects all resources
// - Class field sits in association bits 63:32
// - Reset: class 0 mask all ones, class 0
package cacap_pkg;
   localparam int          CACAP_MASK_LEN    = 16;
   localparam int          CACAP_NUM_CLASS   = 16;
   localparam int          CACAP_NUM_CPU     = 2;
   localparam int          CACAP_CLS_W       = 4;
   localparam int          CACAP_CPU_W       = 1;
   localparam logic [31:0] CACAP_LEAF_FEAT   = 32'h0000_0007;
   localparam logic [31:0] CACAP_LEAF_ALLOC  = 32'h0000_0010;
   localparam logic [31:0] CACAP_SUB_ENUM    = 32'h0000_0000;
   localparam logic [31:0] CACAP_SUB_LLC     = 32'h0000_0001;
   localparam logic [31:0] CACAP_SUB_L2      = 32'h0000_0002;
   localparam int          CACAP_BIT_PRESENT = 15;
   localparam int          CACAP_BIT_LLC     = 1;
   localparam int          CACAP_BIT_L2      = 2;
   localparam int          CACAP_BIT_AGENT   = 1;
   localparam int          CACAP_BIT_SPLIT   = 2;
   localparam int          CACAP_BIT_NONCONT = 3;
   localparam int          CACAP_LEN_W       = 5;
   localparam int          CACAP_HICLS_W     = 16;
   localparam int          CACAP_ASSOC_LSB   = 32;
   localparam logic [CACAP_MASK_LEN-1:0] CACAP_MASK_RST = 16'hFFFF;
   localparam logic [CACAP_CLS_W-1:0]    CACAP_CLS_RST  = 4'h0;

   typedef struct packed {
      logic        valid;
      logic [31:0] leaf;
      logic [31:0] sub_leaf;
   } cacap_query_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] word_a;
      logic [31:0] word_b;
      logic [31:0] word_c;
      logic [31:0] word_d;
   } cacap_result_s;

   typedef struct packed {
      logic        llc_en;
      logic        l2_en;
      logic        agent;
      logic        llc_split;
      logic        l2_split;
      logic        llc_noncont;
      logic        l2_noncont;
      logic [15:0] llc_shared;
      logic [15:0] l2_shared;
   } cacap_caps_s;

   typedef struct packed {
      logic                   wr;
      logic                   is_l2;
      logic [CACAP_CLS_W-1:0] cls;
      logic [15:0]            data;
   } cacap_mask_wr_s;
endpackage

//--- cacap_top.sv
`timescale 1ns/10ps
module cacap_top
   import cacap_pkg::*;
(
   input  wire logic                              sys_clk_i,
   input  wire logic                              reset_n_i,
   input  wire cacap_pkg::cacap_caps_s            caps_i,
   input  wire cacap_pkg::cacap_query_s           query_i,
   output cacap_pkg::cacap_result_s               result_o,
   input  wire cacap_pkg::cacap_mask_wr_s         mask_wr_i,
   input  wire logic                              assoc_wr_i,
   input  wire logic [cacap_pkg::CACAP_CPU_W-1:0] assoc_cpu_i,
   input  wire logic [63:0]                       assoc_data_i,
   output logic      [cacap_pkg::CACAP_NUM_CPU-1:0][15:0] llc_mask_o,
   output logic      [cacap_pkg::CACAP_NUM_CPU-1:0][15:0] l2_mask_o
);
   import cacap_pkg::*;

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      cacap_result_s res;
   } cacap_top_s;

   cacap_top_s st_q;
   cacap_top_s st_d;

   logic [CACAP_NUM_CPU-1:0][CACAP_CLS_W-1:0] cls;

   // Shared bits beyond the mask length are reserved and forced to zero
   function automatic logic [31:0] clip_map(input logic [15:0] m);
      clip_map = {16'h0000, m};
   endfunction

   function automatic logic [31:0] feat_word(input logic agent, input logic split,
                                             input logic noncont);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[CACAP_BIT_AGENT] = agent;
      w[CACAP_BIT_SPLIT] = split;
      w[CACAP_BIT_NONCONT] = noncont;
      feat_word = w;
   endfunction

   //------------------------------------------------------------
   // Query decode
   //------------------------------------------------------------
   always_comb begin
      logic [31:0] len_w;
      logic [31:0] hi_w;
      len_w = 32'h0000_0000;
      hi_w = 32'h0000_0000;
      len_w[CACAP_LEN_W-1:0] = 5'(CACAP_MASK_LEN - 1);
      hi_w[CACAP_HICLS_W-1:0] = 16'(CACAP_NUM_CLASS - 1);
      st_d = '0;
      st_d.res.valid = query_i.valid;
      if (query_i.valid) begin
         if (query_i.leaf == CACAP_LEAF_FEAT && query_i.sub_leaf == CACAP_SUB_ENUM) begin
            st_d.res.word_b[CACAP_BIT_PRESENT] = caps_i.llc_en | caps_i.l2_en;
         end else if (query_i.leaf == CACAP_LEAF_ALLOC) begin
            case (query_i.sub_leaf)
               CACAP_SUB_ENUM: begin
                  st_d.res.word_b[CACAP_BIT_LLC] = caps_i.llc_en;
                  st_d.res.word_b[CACAP_BIT_L2]  = caps_i.l2_en;
               end
               CACAP_SUB_LLC: begin
                  if (caps_i.llc_en) begin
                     st_d.res.word_a = len_w;
                     st_d.res.word_b = clip_map(caps_i.llc_shared);
                     st_d.res.word_c = feat_word(caps_i.agent, caps_i.llc_split,
                                                 caps_i.llc_noncont);
                     st_d.res.word_d = hi_w;
                  end
               end
               CACAP_SUB_L2: begin
                  if (caps_i.l2_en) begin
                     st_d.res.word_a = len_w;
                     st_d.res.word_b = clip_map(caps_i.l2_shared);
                     st_d.res.word_c = feat_word(1'b0, caps_i.l2_split,
                                                 caps_i.l2_noncont);
                     st_d.res.word_d = hi_w;
                  end
               end
               default: st_d.res.valid = query_i.valid;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign result_o = st_q.res;

   //------------------------------------------------------------
   // Class selection and mask banks
   //------------------------------------------------------------
   cacap_assoc u_assoc (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .wr_i      (assoc_wr_i),
      .wr_cpu_i  (assoc_cpu_i),
      .wr_data_i (assoc_data_i),
      .cls_o     (cls)
   );

   // One class value picks the mask in both caches
   cacap_mask_bank u_llc_bank (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .wr_i        (mask_wr_i.wr & ~mask_wr_i.is_l2),
      .wr_cls_i    (mask_wr_i.cls),
      .wr_data_i   (mask_wr_i.data),
      .rd_cls_a_i  (cls[0]),
      .rd_cls_b_i  (cls[1]),
      .rd_mask_a_o (llc_mask_o[0]),
      .rd_mask_b_o (llc_mask_o[1])
   );

   cacap_mask_bank u_l2_bank (
      .sys_clk_i   (sys_clk_i),
      .reset_n_i   (reset_n_i),
      .wr_i        (mask_wr_i.wr & mask_wr_i.is_l2),
      .wr_cls_i    (mask_wr_i.cls),
      .wr_data_i   (mask_wr_i.data),
      .rd_cls_a_i  (cls[0]),
      .rd_cls_b_i  (cls[1]),
      .rd_mask_a_o (l2_mask_o[0]),
      .rd_mask_b_o (l2_mask_o[1])
   );

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   sequence q_alloc(logic [31:0] s);
      query_i.valid && query_i.leaf == CACAP_LEAF_ALLOC && query_i.sub_leaf == s;
   endsequence

   AST_PRESENT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      query_i.valid && query_i.leaf == CACAP_LEAF_FEAT && query_i.sub_leaf == CACAP_SUB_ENUM
      |=> result_o.word_b[CACAP_BIT_PRESENT] == $past(caps_i.llc_en | caps_i.l2_en))
      else $error("presence bit wrong");
   AST_ENUM_RSVD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_ENUM) |=> result_o.word_a == 0 && result_o.word_c == 0
      && result_o.word_d == 0 && result_o.word_b[0] == 1'b0)
      else $error("enum reserved words not zero");
   AST_ENUM_FLAGS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_ENUM) |=> result_o.word_b[2:1] == $past({caps_i.l2_en, caps_i.llc_en}))
      else $error("resource flags wrong");
   AST_LEN: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_LLC) and caps_i.llc_en |=> result_o.word_a == 32'h0000_000F)
      else $error("mask length wrong");
   AST_HICLS: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_L2) and caps_i.l2_en |=> result_o.word_d == 32'h0000_000F)
      else $error("highest class wrong");
   AST_LLC_MAP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_LLC) and caps_i.llc_en
      |=> result_o.word_b == {16'h0000, $past(caps_i.llc_shared)})
      else $error("llc shared map wrong");
   AST_L2_FEAT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_L2) and caps_i.l2_en |=> result_o.word_c[1:0] == 2'h0
      && result_o.word_c[3:2] == $past({caps_i.l2_noncont, caps_i.l2_split}))
      else $error("l2 feature word wrong");
   AST_LLC_FEAT: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_LLC) and caps_i.llc_en |=> result_o.word_c[3:1]
      == $past({caps_i.llc_noncont, caps_i.llc_split, caps_i.agent}))
      else $error("llc feature word wrong");
   AST_UNSUP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      q_alloc(CACAP_SUB_LLC) and !caps_i.llc_en |=> result_o.word_a == 0 && result_o.word_b == 0)
      else $error("unsupported sub-leaf not zero");
   AST_ASSOC_SEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
      $rose(reset_n_i) |-> llc_mask_o[0] == CACAP_MASK_RST)
      else $error("processor 0 mask not class 0 after reset");
endmodule

//--- test_cache_alloc_capability_enum.sv
`timescale 1ns/10ps
module test_cache_alloc_capability_enum;
   import cacap_pkg::*;
   localparam int LIMIT = 5000;
   logic                            sys_clk_i    = 1'b0;
   logic                            reset_n_i    = 1'b0;
   cacap_caps_s                     caps_i       = '0;
   cacap_query_s                    query_i      = '0;
   cacap_result_s                   result_o;
   cacap_mask_wr_s                  mask_wr_i    = '0;
   logic                            assoc_wr_i   = 1'b0;
   logic [CACAP_CPU_W-1:0]          assoc_cpu_i  = '0;
   logic [63:0]                     assoc_data_i = '0;
   logic [CACAP_NUM_CPU-1:0][15:0]  llc_mask_o;
   logic [CACAP_NUM_CPU-1:0][15:0]  l2_mask_o;
   int                              err_total    = 0;
   int                              num_checks   = 0;
   int                              cycles       = 0;
   logic                            chk_en       = 1'b0;
   logic [31:0]                     seed         = 32'h0001_0335;
   logic [31:0]                     r1, r2, r3;
   cacap_result_s                   exp_res;
   logic [15:0]                     llc_bank [CACAP_NUM_CLASS];
   logic [15:0]                     l2_bank  [CACAP_NUM_CLASS];
   logic [CACAP_CLS_W-1:0]          cls_m    [CACAP_NUM_CPU];

   always #50 sys_clk_i = ~sys_clk_i;

   cacap_top uut (
      .sys_clk_i    (sys_clk_i),
      .reset_n_i    (reset_n_i),
      .caps_i       (caps_i),
      .query_i      (query_i),
      .result_o     (result_o),
      .mask_wr_i    (mask_wr_i),
      .assoc_wr_i   (assoc_wr_i),
      .assoc_cpu_i  (assoc_cpu_i),
      .assoc_data_i (assoc_data_i),
      .llc_mask_o   (llc_mask_o),
      .l2_mask_o    (l2_mask_o)
   );

   // ------------------------------------------------------------
   // Expectation helpers
   // ------------------------------------------------------------
   // Steps 32 times so successive draws share no bits
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      for (int i = 0; i < 32; i++) begin
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      end
      return s;
   endfunction

   function automatic cacap_result_s expect_res(input cacap_caps_s c, input cacap_query_s q);
      cacap_result_s r;
      r = '0;
      r.valid = 1'b1;
      if (q.leaf == CACAP_LEAF_FEAT && q.sub_leaf == CACAP_SUB_ENUM) begin
         r.word_b[15] = c.llc_en | c.l2_en;
      end else if (q.leaf == CACAP_LEAF_ALLOC && q.sub_leaf == CACAP_SUB_ENUM) begin
         r.word_b[1] = c.llc_en;
         r.word_b[2] = c.l2_en;
      end else if (q.leaf == CACAP_LEAF_ALLOC && q.sub_leaf == CACAP_SUB_LLC && c.llc_en) begin
         r.word_a = 32'h0000_000F;
         r.word_b = {16'h0000, c.llc_shared};
         r.word_c = {28'h0000_000, c.llc_noncont, c.llc_split, c.agent, 1'b0};
         r.word_d = 32'h0000_000F;
      end else if (q.leaf == CACAP_LEAF_ALLOC && q.sub_leaf == CACAP_SUB_L2 && c.l2_en) begin
         r.word_a = 32'h0000_000F;
         r.word_b = {16'h0000, c.l2_shared};
         r.word_c = {28'h0000_000, c.l2_noncont, c.l2_split, 2'h0};
         r.word_d = 32'h0000_000F;
      end
      return r;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] expv, input string what);
      num_checks++;
      if (seen !== expv) begin
         err_total++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, expv);
      end
   endtask

   task automatic final_report;
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic query(input logic [31:0] leaf, input logic [31:0] sub);
      @(posedge sys_clk_i);
      query_i <= {1'b1, leaf, sub};
   endtask

   // ------------------------------------------------------------
   // Reference model, sampled on the same edge as the design
   // ------------------------------------------------------------
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (!reset_n_i) begin
         exp_res <= '0;
         for (int i = 0; i < CACAP_NUM_CLASS; i++) begin
            llc_bank[i] <= 16'hFFFF;
            l2_bank[i]  <= 16'hFFFF;
         end
         for (int i = 0; i < CACAP_NUM_CPU; i++) begin
            cls_m[i] <= '0;
         end
      end else begin
         exp_res <= query_i.valid ? expect_res(caps_i, query_i) : '0;
         if (mask_wr_i.wr && mask_wr_i.is_l2) begin
            l2_bank[mask_wr_i.cls] <= mask_wr_i.data;
         end else if (mask_wr_i.wr) begin
            llc_bank[mask_wr_i.cls] <= mask_wr_i.data;
         end
         if (assoc_wr_i) begin
            cls_m[assoc_cpu_i] <= assoc_data_i[35:32];
         end
      end
   end

   // Compare away from the edge so every update has landed
   always @(negedge sys_clk_i) begin
      if (cycles >= LIMIT) begin
         err_total++;
         final_report();
      end else if (chk_en) begin
         check(32'(result_o.valid), 32'(exp_res.valid), "valid");
         check(result_o.word_a, exp_res.word_a, "word a");
         check(result_o.word_b, exp_res.word_b, "word b");
         check(result_o.word_c, exp_res.word_c, "word c");
         check(result_o.word_d, exp_res.word_d, "word d");
         for (int i = 0; i < CACAP_NUM_CPU; i++) begin
            check(32'(llc_mask_o[i]), 32'(llc_bank[cls_m[i]]), "llc mask");
            check(32'(l2_mask_o[i]), 32'(l2_bank[cls_m[i]]), "l2 mask");
         end
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge sys_clk_i);
      chk_en <= 1'b1;
      repeat (8) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         caps_i <= (k == 0) ? '1 : ((k == 1) ? '0 : {7'h55, 16'hA5C3, 16'h8001});
         query(CACAP_LEAF_FEAT, CACAP_SUB_ENUM);
         query(CACAP_LEAF_ALLOC, CACAP_SUB_ENUM);
         query(CACAP_LEAF_ALLOC, CACAP_SUB_LLC);
         query(CACAP_LEAF_ALLOC, CACAP_SUB_L2);
         query(CACAP_LEAF_ALLOC, 32'h0000_0003);
         query(CACAP_LEAF_FEAT, CACAP_SUB_LLC);
         query(CACAP_LEAF_ALLOC, 32'h0001_0001);
         query(32'h0000_0005, CACAP_SUB_ENUM);
      end
      @(posedge sys_clk_i);
      query_i.valid <= 1'b0;
      mask_wr_i     <= {1'b1, 1'b0, 4'hF, 16'h00F0};
      assoc_wr_i    <= 1'b1;
      assoc_cpu_i   <= 1'b1;
      assoc_data_i  <= 64'h0000_000F_0000_0000;
      @(posedge sys_clk_i);
      mask_wr_i     <= {1'b1, 1'b1, 4'h3, 16'h0003};
      assoc_cpu_i   <= 1'b0;
      assoc_data_i  <= 64'hFFFF_FFF3_0000_0000;
      @(posedge sys_clk_i);
      mask_wr_i.wr  <= 1'b0;
      assoc_wr_i    <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      $display("Directed queries and class writes done");
      repeat (2000) begin
         @(posedge sys_clk_i);
         r1 = lfsr(seed);
         r2 = lfsr(r1);
         r3 = lfsr(r2);
         seed = r3;
         query_i <= {r1[0],
                     (r1[2:1] == 2'h0) ? CACAP_LEAF_FEAT :
                     ((r1[2:1] == 2'h3) ? {24'h0000_00, r2[7:0]} : CACAP_LEAF_ALLOC),
                     r1[3] ? r3 : {29'h0000_0000, r1[6:4]}};
         if (r1[7]) begin
            caps_i <= {r2[6:0], r3};
         end
         mask_wr_i    <= {r1[8], r1[9], r1[13:10], r1[31:16]};
         assoc_wr_i   <= r1[14];
         assoc_cpu_i  <= r1[15];
         assoc_data_i <= {r2, r3};
      end
      $display("Random traffic done");
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      query_i   <= {1'b1, CACAP_LEAF_ALLOC, CACAP_SUB_LLC};
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      query(CACAP_LEAF_ALLOC, CACAP_SUB_L2);
      @(posedge sys_clk_i);
      query_i.valid <= 1'b0;
      mask_wr_i.wr  <= 1'b0;
      assoc_wr_i    <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      $display("Mid-run reset done");
      final_report();
   end
endmodule
